// ===== pkg/nv_access_map.vh
`ifndef NV_ACCESS_MAP_VH
`define NV_ACCESS_MAP_VH
// Operation
// - Write needs prior latch-set command frame
// - Three address bytes, top six bits ignored
// - Write stores each byte, address wraps
// - Byte committed at eighth bit, no limit
// - Chip select rise ends write, partial dropped
// - Protect pin change applies next frame
// - Read command then three address bytes
// - After read address, serial input ignored
// - Read MSB first, address increments, wraps
// - Chip select rise ends read output
// - Pause input freezes and resumes transaction
// - Clock and select ignored while paused
// - Sleep command plus select rise sleeps
// - Asleep: clock, input ignored, output off
// - Select fall wakes within recovery time
// - Output stays off during wake-up
// - Command encodings, one command per frame
// - Sample on rising, drive on falling
// - Write frame end clears write latch; code clears it only once all three address bytes are in
// - Region guard bits block protected ranges

// ==========================================
// Command bytes
`define CMD_SET_WRITE_LATCH 8'h06
`define CMD_READ_MEM 8'h03
`define CMD_WRITE_MEM 8'h02
`define CMD_SLEEP 8'hB9

// ==========================================
// Address layout
`define ADDR_BITS 18
`define ADDR_SHIFT_BITS 24
`define BYTE_BITS 8
`define GUARD_QUARTER_BASE 18'h30000
`define GUARD_HALF_BASE 18'h20000

// ==========================================
// Timing
`define CLK_PERIOD_NS 5
`define WAKE_RECOVERY_TIME_NS 450000
`define WAKE_RECOVERY_CYCLES (`WAKE_RECOVERY_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== core/nv_access_core.v
`include "nv_access_map.vh"

module nv_access_core #(
   parameter ADDR_W = `ADDR_BITS,
   parameter WAKE_CYCLES = `WAKE_RECOVERY_CYCLES
) (
   input wire clk_sys,
   input wire reset,
   input wire spi_cs_n,
   input wire spi_sck,
   input wire spi_mosi,
   input wire hold_n,
   input wire write_protect_n,
   input wire region_guard_hi,
   input wire region_guard_lo,
   output reg spi_miso_r,
   output reg spi_miso_oe_r,
   output reg write_latch_flag_r,
   output reg protect_frame_r,
   output reg asleep_r,
   output reg paused_r
);

   // ==========================================
   // States
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_DONE = 3'h5;
   localparam [2:0] ST_SLEEP = 3'h6;
   localparam [2:0] ST_WAKE = 3'h7;

   localparam DEPTH = 1 << ADDR_W;

   // ==========================================
   // Helpers
   function guarded;
      input [ADDR_W-1:0] a;
      input hi;
      input lo;
      begin
         case ({hi, lo})
            2'h1: guarded = (a >= `GUARD_QUARTER_BASE);
            2'h2: guarded = (a >= `GUARD_HALF_BASE);
            2'h3: guarded = 1'b1;
            default: guarded = 1'b0;
         endcase
      end
   endfunction

   function [ADDR_W-1:0] addr_inc;
      input [ADDR_W-1:0] a;
      begin
         // Natural overflow gives the wrap to zero
         addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // ==========================================
   // Storage and state
   reg [7:0] mem [0:DEPTH-1];
   reg [2:0] state_r;
   reg [4:0] bit_cnt_r;
   reg [7:0] cmd_r;
   reg [`ADDR_SHIFT_BITS-1:0] addr_sh_r;
   reg [ADDR_W-1:0] addr_r;
   reg [7:0] in_sh_r;
   reg [7:0] out_sh_r;
   reg sleep_pend_r;
   reg sck_q_r;
   reg cs_q_r;
   reg [31:0] wake_cnt_r;
   reg rd_live_r;

   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire cs_rise;
   wire frozen;
   wire [7:0] byte_in;
   wire [`ADDR_SHIFT_BITS-1:0] addr_full;
   wire [ADDR_W-1:0] addr_next;

   // Pause blocks every edge, so select toggles cannot end a frame
   assign frozen = paused_r;
   assign sck_rise = spi_sck & ~sck_q_r & ~frozen;
   assign sck_fall = ~spi_sck & sck_q_r & ~frozen;
   assign cs_fall = ~spi_cs_n & cs_q_r & ~frozen;
   assign cs_rise = spi_cs_n & ~cs_q_r & ~frozen;
   assign byte_in = {in_sh_r[6:0], spi_mosi};
   assign addr_full = {addr_sh_r[`ADDR_SHIFT_BITS-2:0], spi_mosi};
   assign addr_next = addr_inc(addr_r);

   // ==========================================
   // Edge history
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sck_q_r <= 1'b0;
         cs_q_r <= 1'b1;
      end else begin
         sck_q_r <= spi_sck;
         cs_q_r <= spi_cs_n;
      end
   end

   // ==========================================
   // Pause: level only moves while the clock is low
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         paused_r <= 1'b0;
      end else if (!spi_sck && state_r != ST_SLEEP && state_r != ST_WAKE) begin
         paused_r <= ~hold_n;
      end
   end

   // ==========================================
   // Frame sequencer
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 5'h00;
         cmd_r <= 8'h00;
         addr_sh_r <= {`ADDR_SHIFT_BITS{1'b0}};
         addr_r <= {ADDR_W{1'b0}};
         in_sh_r <= 8'h00;
         out_sh_r <= 8'h00;
         sleep_pend_r <= 1'b0;
         write_latch_flag_r <= 1'b0;
         protect_frame_r <= 1'b0;
         wake_cnt_r <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_SLEEP: begin
               // Clock and data are not looked at here
               if (!spi_cs_n && cs_q_r) begin
                  state_r <= ST_WAKE;
                  wake_cnt_r <= 32'h0000_0000;
               end
            end
            ST_WAKE: begin
               // Commands inside the recovery window are dropped
               if (wake_cnt_r >= WAKE_CYCLES - 1) begin
                  state_r <= ST_IDLE;
               end else begin
                  wake_cnt_r <= wake_cnt_r + 32'h0000_0001;
               end
            end
            default: begin
               if (cs_rise) begin
                  // Trailing partial byte is simply abandoned
                  if (state_r == ST_WDATA) begin
                     write_latch_flag_r <= 1'b0;
                  end
                  if (sleep_pend_r) begin
                     state_r <= ST_SLEEP;
                  end else begin
                     state_r <= ST_IDLE;
                  end
                  sleep_pend_r <= 1'b0;
               end else if (cs_fall) begin
                  state_r <= ST_CMD;
                  bit_cnt_r <= 5'h00;
                  sleep_pend_r <= 1'b0;
                  protect_frame_r <= ~write_protect_n;
               end else if (sck_rise && !spi_cs_n) begin
                  case (state_r)
                     ST_CMD: begin
                        in_sh_r <= byte_in;
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'h07) begin
                           cmd_r <= byte_in;
                           bit_cnt_r <= 5'h00;
                           case (byte_in)
                              `CMD_SET_WRITE_LATCH: begin
                                 write_latch_flag_r <= 1'b1;
                                 state_r <= ST_DONE;
                              end
                              `CMD_READ_MEM: state_r <= ST_ADDR;
                              `CMD_WRITE_MEM: state_r <= ST_ADDR;
                              `CMD_SLEEP: begin
                                 sleep_pend_r <= 1'b1;
                                 state_r <= ST_DONE;
                              end
                              default: state_r <= ST_DONE;
                           endcase
                        end
                     end
                     ST_ADDR: begin
                        addr_sh_r <= addr_full;
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'h17) begin
                           // Upper six bits of the first byte drop out here
                           addr_r <= addr_full[ADDR_W-1:0];
                           bit_cnt_r <= 5'h00;
                           if (cmd_r == `CMD_READ_MEM) begin
                              out_sh_r <= mem[addr_full[ADDR_W-1:0]];
                              state_r <= ST_RDATA;
                           end else begin
                              state_r <= ST_WDATA;
                           end
                        end
                     end
                     ST_WDATA: begin
                        in_sh_r <= byte_in;
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'h07) begin
                           bit_cnt_r <= 5'h00;
                           // Committed at once, no page buffer
                           if (write_latch_flag_r &&
                               !guarded(addr_r, region_guard_hi, region_guard_lo)) begin
                              mem[addr_r] <= byte_in;
                           end
                           addr_r <= addr_next;
                        end
                     end
                     default: begin
                     end
                  endcase
               end else if (sck_fall && !spi_cs_n && state_r == ST_RDATA) begin
                  // Serial input is never sampled in this state
                  out_sh_r <= {out_sh_r[6:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == 5'h07) begin
                     bit_cnt_r <= 5'h00;
                     addr_r <= addr_next;
                     out_sh_r <= mem[addr_next];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================
   // Read output live once the first bit has been driven
   // Lets a resumed pause drive the held bit again
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_live_r <= 1'b0;
      end else if (state_r != ST_RDATA) begin
         rd_live_r <= 1'b0;
      end else if (sck_fall) begin
         rd_live_r <= 1'b1;
      end
   end

   // ==========================================
   // Serial output
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         spi_miso_r <= 1'b0;
         spi_miso_oe_r <= 1'b0;
      end else begin
         if (state_r == ST_SLEEP || state_r == ST_WAKE) begin
            spi_miso_oe_r <= 1'b0;
         end else if (cs_rise || spi_cs_n || paused_r) begin
            spi_miso_oe_r <= 1'b0;
         end else if (sck_fall && state_r == ST_RDATA) begin
            spi_miso_r <= out_sh_r[7];
            spi_miso_oe_r <= 1'b1;
         end else if (state_r == ST_RDATA && rd_live_r) begin
            spi_miso_oe_r <= 1'b1;
         end
      end
   end

   // ==========================================
   // Sleep status
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         asleep_r <= 1'b0;
      end else begin
         asleep_r <= (state_r == ST_SLEEP) || (state_r == ST_WAKE);
      end
   end

endmodule

// ===== testbench/nv_access_checker.sv
module nv_access_checker #(
   parameter WAKE_CYCLES = 20
) (
   input logic clk_sys,
   input logic reset,
   input logic spi_cs_n,
   input logic spi_sck,
   input logic spi_miso_r,
   input logic spi_miso_oe_r,
   input logic write_latch_flag_r,
   input logic protect_frame_r,
   input logic asleep_r,
   input logic paused_r
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // Wake length, counted from the raw select fall, ahead of the sync
   int unsigned wake_cnt_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   always @(posedge clk_sys or posedge reset) begin
      if (reset)
         wake_cnt_r <= 0;
      else if (!asleep_r)
         wake_cnt_r <= 0;
      else if (!spi_cs_n || wake_cnt_r != 0)
         wake_cnt_r <= wake_cnt_r + 1;
   end
   AST_SLEEP_OE: assert property (asleep_r |-> !spi_miso_oe_r)
      else $error("output driven while asleep");
   AST_SLEEP_IN: assert property ($rose(asleep_r) |-> $past(spi_cs_n))
      else $error("sleep entered inside a frame");
   AST_WAKE_MAX: assert property (wake_cnt_r <= WAKE_CYCLES + 6)
      else $error("wake took too long");
   AST_WAKE_MIN: assert property ($fell(asleep_r) |-> wake_cnt_r >= WAKE_CYCLES - 1)
      else $error("wake ended early");
   AST_CS_OE: assert property (spi_cs_n [*3] |-> !spi_miso_oe_r)
      else $error("output driven while deselected");
   AST_PAUSE_OE: assert property (paused_r [*3] |-> !spi_miso_oe_r)
      else $error("output driven while paused");
   AST_MISO_EDGE: assert property ($changed(spi_miso_r) && spi_miso_oe_r |-> !$past(spi_sck))
      else $error("output moved with clock high");
   AST_LATCH_SET: assert property ($rose(write_latch_flag_r) |-> !spi_cs_n)
      else $error("latch set outside a frame");
   AST_LATCH_CLR: assert property ($fell(write_latch_flag_r) |-> $past(spi_cs_n))
      else $error("latch cleared inside a frame");
   AST_PROTECT: assert property ($changed(protect_frame_r) |-> !$past(spi_cs_n))
      else $error("protect level moved off a select fall");
endmodule

bind nv_access_core nv_access_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (
   .clk_sys(clk_sys), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
   .spi_miso_r(spi_miso_r), .spi_miso_oe_r(spi_miso_oe_r),
   .write_latch_flag_r(write_latch_flag_r), .protect_frame_r(protect_frame_r),
   .asleep_r(asleep_r), .paused_r(paused_r));

// ===== testbench/spi_master_model.sv
module spi_master_model (
   input wire clk_sys,
   input wire miso,
   input wire miso_oe,
   output logic cs_n,
   output logic sck,
   output logic mosi,
   output logic hold_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // Mode 0 master; halves of 4 clocks leave room for the input sync
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   task automatic half(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      for (int i = 7; i > 7 - n; i--) begin
         mosi <= tx[i];
         half(4);
         sck <= 1'b1;
         rx[i] = miso_oe ? miso : 1'bx;
         half(4);
         sck <= 1'b0;
      end
   endtask
   task automatic select(input logic level);
      half(2);
      cs_n <= level;
      half(6);
   endtask
   task automatic pause(input logic level);
      half(3);
      hold_n <= level;
      half(6);
   endtask
endmodule

// ===== testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic wp_n = 1'b1;
   logic g_hi = 1'b0;
   logic g_lo = 1'b0;
   wire cs_n, sck, mosi, hold_n, miso, oe, wlf, prot, asleep, paused;
   logic [7:0] rx, h, d, e;
   logic [23:0] a;
   logic [1:0] g;
   int failures = 0;
   int compares = 0;
   // Address, data, guard, expected readback
   localparam logic [41:0] rows [6] = '{
      {24'hFC0010, 8'h3C, 2'h0, 8'h3C}, {24'h02FFFF, 8'h4B, 2'h1, 8'h4B},
      {24'h030000, 8'h5A, 2'h1, 8'hA5}, {24'h02FFFF, 8'h69, 2'h2, 8'hA5},
      {24'h01FFFF, 8'h78, 2'h2, 8'h78}, {24'h000000, 8'h87, 2'h3, 8'hA5}};
   always #2.5 clk_sys = ~clk_sys;
   nv_access_core #(.WAKE_CYCLES(20)) dut_u (.clk_sys(clk_sys), .reset(reset),
      .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .hold_n(hold_n),
      .write_protect_n(wp_n), .region_guard_hi(g_hi), .region_guard_lo(g_lo),
      .spi_miso_r(miso), .spi_miso_oe_r(oe), .write_latch_flag_r(wlf),
      .protect_frame_r(prot), .asleep_r(asleep), .paused_r(paused));
   spi_master_model m_u (.clk_sys(clk_sys), .miso(miso), .miso_oe(oe),
      .cs_n(cs_n), .sck(sck), .mosi(mosi), .hold_n(hold_n));
   // ====
   // Compare and bus tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xchg(input logic [7:0] tx, input int n = 8);
      m_u.xfer(tx, n, rx);
   endtask
   task automatic hdr(input logic [7:0] op, input logic [23:0] ad);
      m_u.select(1'b0);
      xchg(op);
      for (int i = 2; i >= 0; i--) xchg(ad[i*8 +: 8]);
   endtask
   task automatic latch;
      m_u.select(1'b0);
      xchg(8'h06);
      chk_bit(wlf, 1'b1);
      m_u.select(1'b1);
   endtask
   task automatic wr(input logic [23:0] wa, input logic [7:0] wd, input logic en);
      if (en)
         latch();
      hdr(8'h02, wa);
      xchg(wd);
      m_u.select(1'b1);
      chk_bit(wlf, 1'b0);
   endtask
   task automatic rd(input logic [23:0] ra, input logic [7:0] re);
      hdr(8'h03, ra);
      xchg(8'hC3);
      chk(rx, re);
      m_u.select(1'b1);
   endtask
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      chk_bit(wlf, 1'b0);
      for (int i = 0; i < 6; i++) begin
         {a, d, g, e} = rows[i];
         {g_hi, g_lo} = 2'b00;
         wr({6'h00, a[17:0]}, 8'hA5, 1'b1);
         {g_hi, g_lo} = g;
         wr(a, d, 1'b1);
         rd({6'h00, a[17:0]}, e);
         $display("row %0d done", i);
      end
      {g_hi, g_lo} = 2'b00;
      wr(24'h000001, 8'h77, 1'b1);
      latch();
      hdr(8'h02, 24'h03FFFF);
      xchg(8'h11);
      xchg(8'h22);
      xchg(8'hEE, 4);
      m_u.select(1'b1);
      hdr(8'h03, 24'h03FFFF);
      xchg(8'h0F);
      chk(rx, 8'h11);
      xchg(8'hF0);
      chk(rx, 8'h22);
      xchg(8'h3C);
      chk(rx, 8'h77);
      m_u.select(1'b1);
      wr(24'h000000, 8'h99, 1'b0);
      rd(24'h000000, 8'h22);
      $display("burst and latch done");
      hdr(8'h03, 24'h03FFFF);
      xchg(8'h00, 4);
      h = rx;
      m_u.pause(1'b0);
      chk_bit(paused, 1'b1);
      xchg(8'h5A);
      m_u.select(1'b1);
      m_u.select(1'b0);
      m_u.pause(1'b1);
      xchg(8'h00, 4);
      chk({h[7:4], rx[7:4]}, 8'h11);
      m_u.select(1'b1);
      latch();
      hdr(8'h02, 24'h000005);
      wp_n = 1'b0;
      xchg(8'h66);
      chk_bit(prot, 1'b0);
      m_u.select(1'b1);
      rd(24'h000005, 8'h66);
      chk_bit(prot, 1'b1);
      wp_n = 1'b1;
      $display("pause and protect done");
      m_u.select(1'b0);
      xchg(8'hB9);
      m_u.select(1'b1);
      chk_bit(asleep, 1'b1);
      hdr(8'h03, 24'h000000);
      xchg(8'hC3);
      chk(rx, 8'hxx);
      m_u.select(1'b1);
      chk_bit(asleep, 1'b0);
      rd(24'h03FFFF, 8'h11);
      latch();
      reset = 1'b1;
      @(negedge clk_sys);
      reset = 1'b0;
      chk_bit(wlf, 1'b0);
      $display("sleep and reset done");
      test_done();
   end
endmodule
